// ### logic/mrsr_pkg.sv
// Constants for the store and self-refresh block
package mrsr_pkg;
    // ---------------------------------------------
    // Clock and timing
    // ---------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int UPDATE_TIME_NS = 190;
    localparam int RFC_TIME_NS = 380;
    localparam int XS_EXTRA_NS = 10;
    localparam int XSDLL_TIME_NS = 2560;
    // Least times round up
    localparam int UPDATE_CYCLES = (UPDATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XS_CYCLES = ((RFC_TIME_NS + XS_EXTRA_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XSDLL_CYCLES = (XSDLL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 10;

    // ---------------------------------------------
    // Organisation
    // ---------------------------------------------
    localparam int NUM_BANKS = 16;
    localparam int BANKS_X16 = 8;
    localparam int SYNC_W = 13;

    // ---------------------------------------------
    // Register map
    // ---------------------------------------------
    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_BUSY = 4'h8;
    localparam int MODE_DLL_EN = 0;
    localparam int MODE_ORG16 = 1;
    localparam int MODE_PARK_EN = 2;
    localparam int MODE_STAGGER_LO = 6;
    localparam int MODE_STORE_EN = 8;
    localparam logic [1:0] STAGGER_RESET = 2'h2;
    localparam logic [8:0] MODE_RESET = 9'h081;
    localparam int STAT_BUSY = 16;
    localparam int STAT_SELF_REF = 17;
    localparam int STAT_DLL_ON = 18;
    localparam int STAT_REENTRY_BLK = 19;
    localparam int STAT_EXIT_WIN = 20;

    typedef enum logic [1:0] {MRSR_IDLE, MRSR_RUN} mrsr_store_t;
endpackage

// ### logic/mrsr_store_ctrl.sv
// Store engine, self-refresh sequencing and register port of the persistent memory
// Behaviour
// (RQ1) Store-enabled refresh stores the addressed banks
// (RQ2) Refresh with store disabled is ignored
// (RQ3) One page buffer per bank, 16/8
// (RQ4) Controller refresh spacing covers bank store
// (RQ5) Storing banks refuse activation for store time
// (RQ6) A10 low stores one bank, high all
// (RQ7) Stagger code sets banks per update
// (RQ8) Controller programs stagger code 10
// (RQ9) DLL off needs stagger code 11
// (RQ10) Self-refresh stores until nothing dirty
// (RQ11) Entry decoded from CS RAS CAS CKE
// (RQ12) Controller enters only from idle
// (RQ13) Controller holds CKE low during stay
// (RQ14) Termination off in, park on exit
// (RQ15) DLL off in, reset on exit
// (RQ16) Internal clock gated, inputs ignored inside
// (RQ17) Controller stops clock only within limits
// (RQ18) Controller waits exit time before commands
// (RQ19) Controller limits early mode writes
// (RQ20) Controller waits locked time before reads
// (RQ21) Controller keeps CKE high after exit
// (RQ22) Controller sends deselect, ODT low
// (RQ23) One store refresh before re-entry
// (RQ24) Per-bank dirty flags track unstored data
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mrsr_store_ctrl
    import mrsr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    input wire logic linkCk,
    input wire logic linkCke,
    input wire logic linkCsN,
    input wire logic linkRasN,
    input wire logic linkCasN,
    input wire logic linkWeN,
    input wire logic linkActN,
    input wire logic linkA10,
    input wire logic [1:0] linkBg,
    input wire logic [1:0] linkBa,
    input wire logic linkOdt,
    input wire logic pageWrite,
    input wire logic [3:0] pageWriteBank,
    output logic [mrsr_pkg::NUM_BANKS-1:0] bankBusy,
    output logic termHiZ,
    output logic termPark,
    output logic dllOn,
    output logic dllReset,
    output logic clkGated,
    output logic exitBusy
);
    import mrsr_pkg::*;

    // ---------------------------------------------
    // Link input synchroniser
    // ---------------------------------------------
    logic [SYNC_W-1:0] pinsRaw;
    logic [SYNC_W-1:0] s1Reg, s2Reg, s3Reg;
    assign pinsRaw = {linkOdt, linkBa, linkBg, linkA10, linkActN, linkWeN, linkCasN, linkRasN, linkCsN,
                      linkCke, linkCk};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1Reg <= '0;
            s2Reg <= '0;
            s3Reg <= '0;
        end else if (clkEn) begin
            s1Reg <= pinsRaw;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
        end
    end

    logic ckLvlReg;
    // Link clock rise counts once stages two and three agree on the new level
    wire ckRise = s2Reg[0] && s3Reg[0] && !ckLvlReg;
    wire ckeNow = s2Reg[1];
    wire csN = s2Reg[2];
    wire rasN = s2Reg[3];
    wire casN = s2Reg[4];
    wire weN = s2Reg[5];
    wire actN = s2Reg[6];
    wire a10 = s2Reg[7];
    wire [1:0] bg = s2Reg[9:8];
    wire [1:0] ba = s2Reg[11:10];
    logic ckePrevReg;

    // ---------------------------------------------
    // Registers
    // ---------------------------------------------
    logic [8:0] modeReg;
    logic [NUM_BANKS-1:0] dirtyReg, busyReg;
    logic inSrReg, dllOnReg, reentryBlkReg, dllResetReg;
    logic [CNT_W-1:0] xsCntReg, xsdllCntReg, updCntReg;
    logic [3:0] grpReg;
    mrsr_store_t stateReg;

    wire storeEn = modeReg[MODE_STORE_EN];
    wire [1:0] stagger = modeReg[MODE_STAGGER_LO+1:MODE_STAGGER_LO];
    wire org16 = modeReg[MODE_ORG16];

    // (RQ3) bank count per organisation
    wire [NUM_BANKS-1:0] bankExist = org16 ? NUM_BANKS'((1 << BANKS_X16) - 1) : {NUM_BANKS{1'b1}};

    // Banks stored in one update: x8 2<<code, x16 1<<code
    function automatic logic [NUM_BANKS-1:0] groupMask(input logic [1:0] code, input logic o16,
                                                       input logic [3:0] grp);
        logic [4:0] bpu;
        logic [NUM_BANKS-1:0] ones;
        bpu = o16 ? (5'h01 << code) : (5'h02 << code);
        ones = NUM_BANKS'((32'h1 << bpu) - 32'h1);
        groupMask = NUM_BANKS'(ones << (grp * bpu));
    endfunction

    function automatic logic [3:0] lastGroup(input logic [1:0] code, input logic o16);
        lastGroup = o16 ? 4'(4'h7 >> code) : 4'(4'h7 >> code);
    endfunction

    // ---------------------------------------------
    // Command decode
    // ---------------------------------------------
    wire ignoreCmds = inSrReg || xsCntReg != '0;
    // (RQ11) entry: CS, RAS, CAS low, CKE falls, WE and ACT high
    wire sreCmd = ckRise && ckePrevReg && !ckeNow && !csN && !rasN && !casN && weN && actN && !ignoreCmds;
    wire refCmd = ckRise && ckePrevReg && ckeNow && !csN && !rasN && !casN && weN && actN && !ignoreCmds;
    // (RQ16) only CKE is looked at while inside
    wire srxCmd = ckRise && inSrReg && ckeNow;
    // (RQ23) re-entry held off until a store refresh
    wire sreTaken = sreCmd && !reentryBlkReg;
    wire idle = stateReg == MRSR_IDLE;
    // (RQ2) store disabled drops the refresh
    wire refStore = refCmd && storeEn && idle;
    wire [3:0] selBank = org16 ? {1'b0, bg[0], ba} : {bg, ba};
    // (RQ6) single bank or all
    wire [NUM_BANKS-1:0] refTarget = a10 ? bankExist : NUM_BANKS'(1) << selBank;
    // (RQ10) keep storing while anything stays dirty
    wire srStore = inSrReg && idle && (dirtyReg & bankExist) != '0;
    wire startStore = refStore || srStore;
    wire [NUM_BANKS-1:0] startMask = refStore ? refTarget : bankExist;
    wire updDone = stateReg == MRSR_RUN && updCntReg == CNT_W'(1);
    wire [NUM_BANKS-1:0] commitMask = updDone ? (groupMask(stagger, org16, grpReg) & busyReg) : '0;
    wire lastUpd = updDone && grpReg == lastGroup(stagger, org16);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ckePrevReg <= 1'b0;
            ckLvlReg <= 1'b0;
        end else if (clkEn) begin
            // A level that the two stages disagree on is still settling
            if (s2Reg[0] == s3Reg[0]) begin
                ckLvlReg <= s3Reg[0];
            end
            if (ckRise) begin
                ckePrevReg <= ckeNow;
            end
        end
    end

    // ---------------------------------------------
    // Store engine
    // ---------------------------------------------
    // (RQ24) a page write wins over a store of the same bank
    wire [NUM_BANKS-1:0] writeSet = pageWrite ? NUM_BANKS'(1) << pageWriteBank : '0;
    // Flags of banks that the organisation drops are cleared, not left stale
    wire [NUM_BANKS-1:0] dirtyNext = ((dirtyReg & ~commitMask) | writeSet) & bankExist;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dirtyReg <= '0;
        end else if (clkEn) begin
            dirtyReg <= dirtyNext;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stateReg <= MRSR_IDLE;
            busyReg <= '0;
            grpReg <= '0;
            updCntReg <= '0;
        end else if (clkEn) begin
            case (stateReg)
                MRSR_IDLE: begin
                    // (RQ1) store-enabled refresh starts a store
                    if (startStore) begin
                        stateReg <= MRSR_RUN;
                        busyReg <= startMask;
                        grpReg <= '0;
                        updCntReg <= CNT_W'(UPDATE_CYCLES);
                    end
                end
                default: begin
                    // (RQ7) one group per update period
                    if (lastUpd) begin
                        stateReg <= MRSR_IDLE;
                        busyReg <= '0;
                    end else if (updDone) begin
                        grpReg <= grpReg + 4'h1;
                        updCntReg <= CNT_W'(UPDATE_CYCLES);
                    end else begin
                        updCntReg <= updCntReg - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // (RQ5) busy banks refuse activation until done
    assign bankBusy = busyReg;

    // ---------------------------------------------
    // Self-refresh entry and exit
    // ---------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inSrReg <= 1'b0;
            dllOnReg <= 1'b1;
            dllResetReg <= 1'b0;
            reentryBlkReg <= 1'b0;
            xsCntReg <= '0;
            xsdllCntReg <= '0;
        end else if (clkEn) begin
            dllResetReg <= 1'b0;
            if (xsCntReg != '0) begin
                xsCntReg <= xsCntReg - CNT_W'(1);
            end
            if (xsdllCntReg != '0) begin
                xsdllCntReg <= xsdllCntReg - CNT_W'(1);
            end
            // (RQ23) a store refresh clears the re-entry hold
            if (refStore) begin
                reentryBlkReg <= 1'b0;
            end
            if (sreTaken) begin
                inSrReg <= 1'b1;
                // (RQ15) DLL stops on entry
                dllOnReg <= 1'b0;
            end else if (srxCmd) begin
                inSrReg <= 1'b0;
                reentryBlkReg <= 1'b1;
                xsCntReg <= CNT_W'(XS_CYCLES);
                xsdllCntReg <= CNT_W'(XSDLL_CYCLES);
                // (RQ15) DLL back with reset when in use
                dllOnReg <= modeReg[MODE_DLL_EN];
                dllResetReg <= modeReg[MODE_DLL_EN];
            end
        end
    end

    // (RQ14) termination high impedance inside, park during locking
    assign termHiZ = inSrReg;
    assign termPark = modeReg[MODE_PARK_EN] && xsdllCntReg != '0;
    // (RQ16) internal clock off while inside
    assign clkGated = inSrReg;
    assign dllOn = dllOnReg;
    assign dllReset = dllResetReg;
    assign exitBusy = xsCntReg != '0;

    // ---------------------------------------------
    // Register port
    // ---------------------------------------------
    wire selMode = regAddr == ADDR_MODE;
    wire selStatus = regAddr == ADDR_STATUS;
    wire selBusy = regAddr == ADDR_BUSY;
    wire [31:0] statusWord = {11'h000, xsdllCntReg != '0, reentryBlkReg, dllOnReg, inSrReg,
                              stateReg == MRSR_RUN, dirtyReg};
    logic [31:0] readMux;

    always_comb begin
        if (selMode) begin
            readMux = {23'h000000, modeReg};
        end else if (selStatus) begin
            readMux = statusWord;
        end else if (selBusy) begin
            readMux = {16'h0000, busyReg};
        end else begin
            readMux = 32'h00000000;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            modeReg <= MODE_RESET;
            regRdata <= 32'h00000000;
        end else if (clkEn) begin
            // Mode changes while storing would corrupt the group walk; hold them off
            if (regWr && selMode && idle) begin
                modeReg <= regWdata[8:0];
            end
            regRdata <= regRd ? readMux : 32'h00000000;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_refresh_no_store: assert property (clkEn && refCmd && !storeEn && idle |=> stateReg == MRSR_IDLE) // RQ2
        else $error("refresh with store disabled changed the engine");
    chk_refresh_starts_store: assert property (clkEn && refCmd && storeEn && idle
                                               |=> stateReg == MRSR_RUN) // RQ1
        else $error("store-enabled refresh did not start a store");
    chk_single_bank_busy: assert property (clkEn && refStore && !a10 |=> $onehot(busyReg)) // RQ6
        else $error("single bank store marked several banks");
    chk_busy_first_update: assert property (clkEn && startStore |=> (bankBusy != '0) [*8]) // RQ5
        else $error("store released banks early");
    chk_bank_limit: assert property (org16 && $past(org16) |-> (dirtyReg & ~bankExist) == '0) // RQ3
        else $error("dirty flag beyond organisation");
    chk_sre_decode: assert property (clkEn && sreTaken |=> inSrReg && termHiZ && clkGated && !dllOn) // RQ11
        else $error("entry did not set self-refresh state");
    chk_exit_dll_reset: assert property (clkEn && srxCmd && modeReg[MODE_DLL_EN]
                                         |=> dllReset ##1 !dllReset) // RQ15
        else $error("exit did not pulse DLL reset once");
    chk_exit_park: assert property (clkEn && srxCmd && modeReg[MODE_PARK_EN] |=> termPark && !termHiZ) // RQ14
        else $error("park termination missing after exit");
    chk_reentry_block: assert property (clkEn && srxCmd |=> reentryBlkReg) // RQ23
        else $error("re-entry hold not set at exit");
    chk_write_wins: assert property (clkEn && pageWrite && bankExist[pageWriteBank]
                                     |=> dirtyReg[$past(pageWriteBank)]) // RQ24
        else $error("page write lost against store");
    chk_sr_drains: assert property (clkEn && inSrReg && idle && (dirtyReg & bankExist) != '0
                                    |=> stateReg == MRSR_RUN) // RQ10
        else $error("self-refresh left dirty data unstored");
    chk_update_step: assert property (clkEn && updDone && !lastUpd |=> grpReg == $past(grpReg) + 4'h1) // RQ7
        else $error("stagger group did not advance");
endmodule
`default_nettype wire

// ### dv/mrsr_ctrl_model.sv
// Command-side model of the memory controller driving the link pins
`timescale 1ns/1ps
`default_nettype none
module mrsr_ctrl_model (
    output logic linkCk,
    output logic linkCke,
    output logic linkCsN,
    output logic [3:0] linkCmd,
    output logic linkA10,
    output logic [3:0] linkBank,
    output logic linkOdt
);
    logic [7:0] noise;

    // ---------------------------------------------
    // Clock and idle bus
    // ---------------------------------------------
    // clock kept running and stable through the stay
    initial begin
        noise = 8'hA5;
        linkCk = 1'b0;
        linkCke = 1'b1;
        linkCsN = 1'b1;
        linkCmd = 4'hF;
        linkA10 = 1'b0;
        linkBank = 4'h0;
        // termination pin held low, also across the locked-exit window
        linkOdt = 1'b0;
        forever #24 linkCk = ~linkCk;
    end

    // Deselected pins carry a changing pattern, not held at the last command
    always @(posedge linkCk) begin
        #10;
        if (linkCsN) begin
            noise = {noise[6:0], noise[7] ^ noise[5]};
            linkCmd = noise[3:0];
            linkA10 = noise[4];
            linkBank = noise[7:4];
        end
    end

    // ---------------------------------------------
    // Command issue: 1 refresh, 2 entry, 3 exit
    // ---------------------------------------------
    // no mode writes or reads are ever issued, so no exit window is cut short
    // refresh and entry share pins, CKE held low until exit with deselect
    task automatic issue(input logic [1:0] code, input logic a10, input logic [3:0] bank);
        // Drive just after the falling edge so a pending release from the last call lands first
        @(negedge linkCk);
        #1;
        if (code != 2'h3) begin
            linkCsN = 1'b0;
            linkCmd = 4'h3;
            linkA10 = a10;
            linkBank = bank;
        end
        linkCke = (code != 2'h2);
        @(posedge linkCk);
        fork
            begin
                @(negedge linkCk);
                linkCsN = 1'b1;
            end
        join_none
    endtask
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the store and self-refresh block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    import mrsr_pkg::*;
    logic sys_clk, reset_n, regWr, regRd, pageWrite;
    logic [3:0] regAddr, pageWriteBank, bank, cmd;
    logic [31:0] regWdata, regRdata, rdv, seed;
    logic [15:0] dirty, busyMask;
    logic [NUM_BANKS-1:0] bankBusy;
    logic termHiZ, termPark, dllOn, dllReset, clkGated, exitBusy;
    logic linkCk, linkCke, linkCsN, linkA10, linkOdt;
    int n_errors, check_count, len, pulses;

    mrsr_store_ctrl mrsr_store_ctrl_i (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(1'b1), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .linkCk(linkCk),
        .linkCke(linkCke), .linkCsN(linkCsN), .linkRasN(cmd[3]), .linkCasN(cmd[2]), .linkWeN(cmd[1]),
        .linkActN(cmd[0]), .linkA10(linkA10), .linkBg(bank[3:2]), .linkBa(bank[1:0]), .linkOdt(linkOdt),
        .pageWrite(pageWrite), .pageWriteBank(pageWriteBank), .bankBusy(bankBusy), .termHiZ(termHiZ),
        .termPark(termPark), .dllOn(dllOn), .dllReset(dllReset), .clkGated(clkGated), .exitBusy(exitBusy));
    mrsr_ctrl_model mrsr_ctrl_model_i (.linkCk(linkCk), .linkCke(linkCke), .linkCsN(linkCsN), .linkCmd(cmd),
        .linkA10(linkA10), .linkBank(bank), .linkOdt(linkOdt));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // Groups of banks per update times one update period
    function automatic int busyLen(input int code);
        return (NUM_BANKS / (2 << code)) * UPDATE_CYCLES;
    endfunction
    function automatic logic watch(input int w);
        return (w == 0) ? ((|bankBusy) === 1'b1) : (w == 1) ? (exitBusy === 1'b1) : (termHiZ === 1'b1);
    endfunction

    // ---------------------------------------------
    // Bus and wait tasks
    // ---------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 rdv = regRdata;
    endtask
    task automatic pageWr();
        seed = xs(seed);
        @(posedge sys_clk);
        pageWrite <= 1'b1;
        pageWriteBank <= seed[3:0];
        dirty[seed[3:0]] = 1'b1;
        @(posedge sys_clk);
        pageWrite <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic waitOn(input int w);
        int k;
        k = 0;
        while (!watch(w) && k < 3000) begin
            @(posedge sys_clk);
            #1 k++;
        end
        if (k >= 3000) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic measure(input int w, output int n);
        waitOn(w);
        busyMask = bankBusy;
        n = 0;
        pulses = 0;
        while (watch(w) && n < 3000) begin
            pulses += int'(dllReset === 1'b1);
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 3000) begin
            n_errors++;
            conclude();
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        {reset_n, regWr, regRd, pageWrite, pageWriteBank, regAddr, regWdata} = '0;
        n_errors = 0;
        check_count = 0;
        dirty = 16'h0000;
        seed = 32'h00012F98;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1;
        `CHK({bankBusy, termHiZ, termPark, dllOn, dllReset, clkGated, exitBusy}, {16'h0000, 6'h08})
        rd(ADDR_MODE);
        `CHK(rdv, 32'h00000081)
        rd(4'hC);
        `CHK(rdv, 32'h00000000)
        repeat (6) pageWr();
        rd(ADDR_STATUS);
        `CHK(rdv, {16'h0004, dirty})
        model_i_ref_off: begin
            mrsr_ctrl_model_i.issue(2'h1, 1'b1, 4'h0);
            repeat (30) @(posedge sys_clk);
            #1;
            `CHK(bankBusy, 16'h0000)
        end
        wr(ADDR_MODE, 32'hFFFFFF81);
        rd(ADDR_MODE);
        `CHK(rdv, 32'h00000181)
        seed = xs(seed);
        mrsr_ctrl_model_i.issue(2'h1, 1'b0, seed[3:0]);
        measure(0, len);
        dirty[seed[3:0]] = 1'b0;
        `CHK(busyMask, 16'h0001 << seed[3:0])
        rd(ADDR_STATUS);
        `CHK(rdv[15:0], dirty)
        // Next refresh only after the store ends, as the controller must space them
        for (int c = 3; c >= 0; c--) begin
            // spacing kept by waiting out each store
            wr(ADDR_MODE, 32'h101 | 32'(c << 6));
            mrsr_ctrl_model_i.issue(2'h1, 1'b1, 4'h0);
            measure(0, len);
            `CHK(len, busyLen(c))
            `CHK(busyMask, 16'hFFFF)
        end
        rd(ADDR_STATUS);
        `CHK(rdv[15:0], 16'h0000)
        // x16 organisation: BG1 is no bank bit, so bank 15 folds onto bank 7
        wr(ADDR_MODE, 32'h00000183);
        mrsr_ctrl_model_i.issue(2'h1, 1'b0, 4'hF);
        measure(0, len);
        `CHK(busyMask, 16'h0080)
        `CHK(len, busyLen(2))
        wr(ADDR_MODE, 32'h00000181);
        repeat (2) pageWr();
        mrsr_ctrl_model_i.issue(2'h1, 1'b1, 4'h0);
        repeat (12) @(posedge sys_clk);
        wr(ADDR_MODE, 32'h00000000);
        measure(0, len);
        rd(ADDR_MODE);
        `CHK(rdv, 32'h00000181)
        // enter only from idle, with park enabled and pages dirty
        wr(ADDR_MODE, 32'h00000185);
        repeat (3) pageWr();
        mrsr_ctrl_model_i.issue(2'h2, 1'b0, 4'h0);
        waitOn(2);
        `CHK({termHiZ, clkGated, dllOn}, 3'b110)
        len = 0;
        rdv = 32'hFFFFFFFF;
        while (rdv[16:0] !== 17'h00000 && len < 200) begin
            rd(ADDR_STATUS);
            len++;
        end
        `CHK(rdv[17:15], 3'b100)
        mrsr_ctrl_model_i.issue(2'h3, 1'b0, 4'h0);
        measure(1, len);
        `CHK(len, XS_CYCLES)
        `CHK(pulses, 1)
        `CHK({termHiZ, termPark, dllOn, clkGated}, 4'b0110)
        mrsr_ctrl_model_i.issue(2'h2, 1'b0, 4'h0);
        repeat (30) @(posedge sys_clk);
        #1;
        `CHK(termHiZ, 1'b0)
        mrsr_ctrl_model_i.issue(2'h3, 1'b0, 4'h0);
        mrsr_ctrl_model_i.issue(2'h1, 1'b1, 4'h0);
        measure(0, len);
        // DLL switched off, so the stagger field goes to 11
        wr(ADDR_MODE, 32'h000001C0);
        mrsr_ctrl_model_i.issue(2'h2, 1'b0, 4'h0);
        waitOn(2);
        repeat (40) @(posedge sys_clk);
        rd(ADDR_BUSY);
        `CHK(rdv, 32'h00000000)
        mrsr_ctrl_model_i.issue(2'h3, 1'b0, 4'h0);
        measure(1, len);
        `CHK(dllOn, 1'b0)
        `CHK(pulses, 0)
        conclude();
    end
endmodule
`default_nettype wire
